// ===== core/sacs_sequencer.sv
`timescale 1ns/10ps
`include "sacs_map.svh"
module sacs_sequencer import sacs_pkg::*; #(
  parameter int NCH = `SACS_NCHAN
) (
  input  wire logic                            clk,
  input  wire logic                            resetn,
  input  wire logic                            ale,
  input  wire logic [2:0]                      channel_select,
  input  wire logic [NCH-1:0][`SACS_NBITS-1:0] analog_channel,
  input  wire logic                            start,
  input  wire logic                            output_enable,
  output logic                                 eoc,
  output logic                                 sample_window,
  output logic [`SACS_NBITS-1:0]               result_bus_o,
  output logic [`SACS_NBITS-1:0]               result_bus_oe
);
  sacs_ctl_s   r_reg;
  sacs_ctl_s   r_next;
  logic        hold_w;
  logic        clear_w;
  logic        step_w;
  logic        load_w;
  sacs_link_if lk ();

  sacs_chan_mux #(.NCH(NCH)) u_mux (
    .clk            (clk),
    .resetn         (resetn),
    .ale            (ale),
    .channel_select (channel_select),
    .analog_channel (analog_channel),
    .lk             (lk)
  );

  sacs_sar u_sar (
    .clk    (clk),
    .resetn (resetn),
    .lk     (lk)
  );

  // Edge n after start falls is the edge that moves cnt to n
  always_comb begin
    r_next  = r_reg;
    hold_w  = 1'b0;
    clear_w = 1'b0;
    step_w  = 1'b0;
    load_w  = 1'b0;
    r_next.oe = {`SACS_NBITS{output_enable}};
    if (start) begin
      // Held start keeps the sequencer at rest; eoc and the output register keep their values
      r_next.state = SACS_ARMED;
      r_next.cnt   = '0;
      r_next.phase = '0;
      r_next.acq   = 1'b0;
      clear_w      = 1'b1;
    end else begin
      case (r_reg.state)
        SACS_IDLE: begin
          r_next.acq = 1'b0;
        end
        SACS_ARMED: begin
          r_next.state = SACS_RUN;
          r_next.cnt   = `SACS_FIRST_EDGE;
        end
        SACS_RUN: begin
          r_next.cnt = r_reg.cnt + 7'd1;
          if (r_next.cnt == `SACS_ACQ_START) begin
            r_next.acq = 1'b1;
          end
          if (r_next.cnt == `SACS_ACQ_END) begin
            r_next.acq   = 1'b0;
            hold_w       = 1'b1;
            r_next.eoc   = 1'b0;
            r_next.phase = '0;
          end
          if (r_reg.cnt >= `SACS_ACQ_END &&
              r_reg.cnt < `SACS_RESULT_EDGE) begin
            if (r_reg.phase == `SACS_BIT_CLKS - 3'd1) begin
              step_w       = 1'b1;
              r_next.phase = '0;
            end else begin
              r_next.phase = r_reg.phase + 3'd1;
            end
          end
          if (r_next.cnt == `SACS_RESULT_EDGE) begin
            load_w        = 1'b1;
            r_next.result = lk.code_next;
          end
          if (r_next.cnt == `SACS_EOC_EDGE) begin
            r_next.eoc   = 1'b1;
            r_next.state = SACS_IDLE;
          end
        end
        default: begin
          r_next.state = SACS_IDLE;
        end
      endcase
    end
  end

  assign lk.hold_load = hold_w;
  assign lk.sar_clear = clear_w;
  assign lk.bit_step  = step_w;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_reg       <= '0;
      r_reg.state <= SACS_IDLE;
      r_reg.eoc   <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign eoc           = r_reg.eoc;
  assign sample_window = r_reg.acq;
  assign result_bus_o  = r_reg.result;
  assign result_bus_oe = r_reg.oe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_run_at(int n);
    r_reg.state == SACS_RUN && r_reg.cnt == 7'(n) && !start;
  endsequence

  a_start_holds_reset: assert property (
    start |=> r_reg.state == SACS_ARMED && r_reg.cnt == 7'd0 && !r_reg.acq)
    else $error("start high did not hold sequencer reset");
  a_restart_midway: assert property (
    r_reg.state == SACS_RUN && start |=> r_reg.state == SACS_ARMED)
    else $error("running conversion not abandoned by start");
  a_first_edge_count: assert property (
    r_reg.state == SACS_ARMED && !start |=> s_run_at(1) or start)
    else $error("first edge after start fall miscounted");
  a_acq_window: assert property (
    s_run_at(8) |-> !r_reg.acq && $past(r_reg.acq) && $past(r_reg.acq, 2) &&
      $past(r_reg.acq, 3) && $past(r_reg.acq, 4) && !$past(r_reg.acq, 5))
    else $error("acquisition window not four periods");
  a_eoc_drop_edge8: assert property (
    s_run_at(7) |=> !r_reg.eoc && $past(hold_w))
    else $error("eoc not low with sample hold on edge 8");
  a_bit_spacing: assert property (
    step_w ##1 !start[*6] |=>
      (step_w || start || r_reg.cnt > 7'd64) && !$past(step_w) &&
      !$past(step_w, 2) && !$past(step_w, 3) && !$past(step_w, 4) &&
      !$past(step_w, 5) && !$past(step_w, 6))
    else $error("bit decisions not seven clocks apart");
  a_result_edge64: assert property (
    s_run_at(63) |=> r_reg.result == $past(lk.code_next) && !r_reg.eoc)
    else $error("result not loaded on edge 64");
  a_eoc_rise_edge65: assert property (
    s_run_at(64) |=> r_reg.eoc && r_reg.state == SACS_IDLE)
    else $error("eoc not high on edge 65");
  a_result_double_buf: assert property (
    !load_w |=> $stable(r_reg.result))
    else $error("output register changed mid conversion");
  a_bus_enable: assert property (
    1'b1 |=> result_bus_oe == (($past(output_enable)) ? 8'hFF : 8'h00))
    else $error("data drive does not follow output enable");
endmodule : sacs_sequencer

// ===== core/sacs_map.svh
`ifndef SACS_MAP_SVH
`define SACS_MAP_SVH
`define SACS_NBITS        8
`define SACS_NCHAN        8
`define SACS_ACQ_START    7'd4
`define SACS_ACQ_END      7'd8
`define SACS_BIT_CLKS     3'd7
`define SACS_RESULT_EDGE  7'd64
`define SACS_EOC_EDGE     7'd65
`define SACS_FIRST_EDGE   7'd1
`define SACS_MSB_INDEX    3'd7
`define SACS_CODE_RESET   8'h00
`endif

// ===== core/sacs_pkg.sv
`include "sacs_map.svh"
package sacs_pkg;
  typedef logic [`SACS_NBITS-1:0] sacs_code_t;
  typedef enum logic [1:0] {SACS_IDLE, SACS_ARMED, SACS_RUN} sacs_state_e;
  typedef struct packed {
    sacs_state_e state;
    logic [6:0]  cnt;
    logic [2:0]  phase;
    logic        eoc;
    logic        acq;
    sacs_code_t  result;
    sacs_code_t  oe;
  } sacs_ctl_s;
  typedef struct packed {
    logic       ale_prev;
    logic [2:0] chan;
    sacs_code_t level;
  } sacs_mux_s;
  typedef struct packed {
    sacs_code_t held;
    sacs_code_t code;
    logic [2:0] idx;
  } sacs_sar_s;
endpackage : sacs_pkg

// ===== core/sacs_link_if.sv
`timescale 1ns/10ps
interface sacs_link_if import sacs_pkg::*; ();
  sacs_code_t live_level;
  logic       hold_load;
  logic       sar_clear;
  logic       bit_step;
  sacs_code_t code_next;
  modport ctl_mp (input code_next, output hold_load, sar_clear, bit_step);
  modport mux_mp (output live_level);
  modport sar_mp (input live_level, hold_load, sar_clear, bit_step,
                  output code_next);
endinterface : sacs_link_if

// ===== core/sacs_chan_mux.sv
`timescale 1ns/10ps
`include "sacs_map.svh"
module sacs_chan_mux import sacs_pkg::*; #(
  parameter int NCH = `SACS_NCHAN
) (
  input  wire logic                              clk,
  input  wire logic                              resetn,
  input  wire logic                              ale,
  input  wire logic [2:0]                        channel_select,
  input  wire logic [NCH-1:0][`SACS_NBITS-1:0]   analog_channel,
  sacs_link_if.mux_mp                            lk
);
  sacs_mux_s r_reg;
  sacs_mux_s r_next;

  always_comb begin
    r_next          = r_reg;
    r_next.ale_prev = ale;
    if (ale && !r_reg.ale_prev) begin
      r_next.chan = channel_select;
    end
    r_next.level = analog_channel[r_reg.chan];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign lk.live_level = r_reg.level;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_chan_latch_rise: assert property (
    ale && !r_reg.ale_prev |=> r_reg.chan == $past(channel_select))
    else $error("channel not latched on strobe rise");
  a_chan_hold_between: assert property (
    !(ale && !r_reg.ale_prev) |=> $stable(r_reg.chan))
    else $error("channel changed without strobe rise");
  a_chan_binary_decode: assert property (
    1'b1 |=> r_reg.level == $past(analog_channel[r_reg.chan]))
    else $error("selected level not from latched index");
endmodule : sacs_chan_mux

// ===== core/sacs_sar.sv
`timescale 1ns/10ps
`include "sacs_map.svh"
module sacs_sar import sacs_pkg::*; (
  input  wire logic clk,
  input  wire logic resetn,
  sacs_link_if.sar_mp lk
);
  sacs_sar_s  r_reg;
  sacs_sar_s  r_next;
  sacs_code_t trial;
  logic       keep;

  always_comb begin
    trial = r_reg.code | (8'h01 << r_reg.idx);
    keep  = r_reg.held >= trial;
  end

  always_comb begin
    r_next = r_reg;
    if (lk.hold_load) begin
      r_next.held = lk.live_level;
    end
    if (lk.sar_clear) begin
      r_next.code = `SACS_CODE_RESET;
      r_next.idx  = `SACS_MSB_INDEX;
    end else if (lk.bit_step) begin
      r_next.code = keep ? trial : r_reg.code;
      r_next.idx  = r_reg.idx - 3'd1;
    end
  end

  // Final decision is visible the same edge so the result load sees it
  assign lk.code_next = r_next.code;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_sample_frozen: assert property (
    !lk.hold_load |=> $stable(r_reg.held))
    else $error("held sample moved outside window close");
  a_sample_taken: assert property (
    lk.hold_load |=> r_reg.held == $past(lk.live_level))
    else $error("sample not stored at window close");
  a_sar_msb_first: assert property (
    lk.sar_clear |=> r_reg.idx == 3'd7 && r_reg.code == 8'h00)
    else $error("approximation not restarted at msb");
  a_sar_bit_decide: assert property (
    lk.bit_step && !lk.sar_clear |=>
      r_reg.code[$past(r_reg.idx)] == $past(keep))
    else $error("trial bit decision wrong");
endmodule : sacs_sar

// ===== tb/sacs_host_model.sv
`timescale 1ns/10ps
module sacs_host_model import sacs_pkg::*; (
  input  wire logic             clk,
  input  wire logic [7:0]       result_bus_o,
  input  wire logic [7:0]       result_bus_oe,
  output logic                  ale,
  output logic [2:0]            channel_select,
  output logic [7:0][7:0]       analog_channel,
  output logic                  start,
  output logic                  output_enable,
  output sacs_code_t            bus_seen
);
  sacs_code_t bus_last = 8'h00;

  initial begin
    ale = 1'h0;
    channel_select = 3'h0;
    analog_channel = '0;
    start = 1'h0;
    output_enable = 1'h0;
  end

  // No pull-ups on the bus: a released bit shows the inverse of its last level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      bus_seen[i] = result_bus_oe[i] ? result_bus_o[i] : ~bus_last[i];
    end
  end

  always_ff @(posedge clk) begin
    bus_last <= bus_seen;
  end

  task automatic latch(input logic [2:0] ch);
    @(negedge clk);
    channel_select = ch;
    ale = 1'h1;
    @(negedge clk);
    ale = 1'h0;
  endtask : latch

  // Start moves on the falling edge, so its setup to the next rising edge
  // is always met and the edge count is exact
  task automatic pulse_start(input int n);
    @(negedge clk);
    start = 1'h1;
    repeat (n) @(negedge clk);
    start = 1'h0;
  endtask : pulse_start
endmodule : sacs_host_model

// ===== tb/sar_adc_conversion_sequencer_test.sv
`timescale 1ns/10ps
module sar_adc_conversion_sequencer_test;
  import sacs_pkg::*;
  // Period is a parameter: a slow source gets a longer window
  localparam int PERIOD = 100;
  typedef struct {logic [2:0] ch; sacs_code_t lvl; sacs_code_t exp;} sacs_row_s;
  logic             clk;
  logic             resetn;
  logic             ale;
  logic [2:0]       channel_select;
  logic [7:0][7:0]  analog_channel;
  logic             start;
  logic             output_enable;
  logic             eoc;
  logic             sample_window;
  sacs_code_t       result_bus_o;
  sacs_code_t       result_bus_oe;
  sacs_code_t       bus_seen;
  int               errors = 0;
  int               n_tests = 0;
  sacs_row_s rows[8] = '{'{3'h0, 8'h00, 8'h00}, '{3'h1, 8'hFF, 8'hFF},
    '{3'h2, 8'h80, 8'h80}, '{3'h3, 8'h7F, 8'h7F}, '{3'h4, 8'h01, 8'h01},
    '{3'h5, 8'hFE, 8'hFE}, '{3'h6, 8'hA5, 8'hA5}, '{3'h7, 8'h5A, 8'h5A}};

  sacs_sequencer #(.NCH(8)) dut_u (
    .clk(clk), .resetn(resetn), .ale(ale), .channel_select(channel_select),
    .analog_channel(analog_channel), .start(start),
    .output_enable(output_enable), .eoc(eoc), .sample_window(sample_window),
    .result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe));

  sacs_host_model host_u (
    .clk(clk), .result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe),
    .ale(ale), .channel_select(channel_select),
    .analog_channel(analog_channel), .start(start),
    .output_enable(output_enable), .bus_seen(bus_seen));

  initial begin
    clk = 1'h0;
    forever #(PERIOD / 2) clk = ~clk;
  end

  task automatic chk_c(input sacs_code_t got, input sacs_code_t exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t code %h expected %h", $time, got, exp);
    end
  endtask : chk_c

  task automatic chk_b(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_b

  task automatic give_verdict();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Inputs are scrambled after the window closes to prove the held sample
  task automatic conv(input sacs_code_t old_v, input sacs_code_t new_v,
                      input logic eoc0, input int len);
    host_u.pulse_start(len);
    for (int k = 1; k <= 65; k++) begin
      @(posedge clk);
      #1;
      if (k == 3 || k == 8) chk_b(sample_window, 1'h0);
      if (k == 4 || k == 7) chk_b(sample_window, 1'h1);
      if (k == 7) chk_b(eoc, eoc0);
      if (k == 8 || k == 64) chk_b(eoc, 1'h0);
      if (k == 63) chk_c(result_bus_o, old_v);
      if (k == 64) chk_c(result_bus_o, new_v);
      if (k == 20) begin
        @(negedge clk);
        host_u.analog_channel = ~host_u.analog_channel;
      end
    end
    chk_b(eoc, 1'h1);
  endtask : conv

  initial begin
    sacs_code_t prev;
    resetn = 1'h0;
    prev = 8'h00;
    repeat (8) @(negedge clk);
    resetn = 1'h1;
    @(negedge clk);
    chk_b(eoc, 1'h1);
    chk_b(sample_window, 1'h0);
    chk_c(result_bus_o, 8'h00);
    chk_c(result_bus_oe, 8'h00);
    foreach (rows[i]) begin
      @(negedge clk);
      for (int j = 0; j < 8; j++) begin
        host_u.analog_channel[j] = ~rows[i].lvl;
      end
      host_u.analog_channel[rows[i].ch] = rows[i].lvl;
      host_u.latch(rows[i].ch);
      conv(prev, rows[i].exp, 1'h1, 1);
      prev = rows[i].exp;
      @(negedge clk);
      host_u.output_enable = 1'h1;
      @(negedge clk);
      chk_c(result_bus_oe, 8'hFF);
      chk_c(bus_seen, prev);
      host_u.output_enable = 1'h0;
      @(negedge clk);
      chk_c(result_bus_oe, 8'h00);
    end
    // Strobe held high: a later select change must not be taken
    @(negedge clk);
    host_u.analog_channel = {8{8'h11}};
    host_u.analog_channel[2] = 8'h3C;
    host_u.analog_channel[6] = 8'hC3;
    host_u.channel_select = 3'h2;
    host_u.ale = 1'h1;
    @(negedge clk);
    host_u.channel_select = 3'h6;
    repeat (3) @(negedge clk);
    conv(prev, 8'h3C, 1'h1, 1);
    host_u.ale = 1'h0;
    prev = 8'h3C;
    // Abort in mid-run, then restart with start held for several edges
    @(negedge clk);
    host_u.analog_channel[2] = 8'h99;
    host_u.pulse_start(1);
    repeat (30) @(posedge clk);
    #1;
    chk_b(eoc, 1'h0);
    chk_c(result_bus_o, prev);
    conv(prev, 8'h99, 1'h0, 4);
    give_verdict();
  end

  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : sar_adc_conversion_sequencer_test
